// File: common/spc_pkg.sv
// Purpose: Shared constants for the stop-mode power control block
// Assumes: 50 MHz system clock, one clock domain
// Notes:   Counts are in oscillator clock cycles
package spc_pkg;
	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned LONG_DLY_CYC    = 4064;
	localparam int unsigned SHORT_DLY_CYC   = 4;
	localparam logic [15:0] LONG_DLY_CNT    = 16'(LONG_DLY_CYC);
	localparam logic [15:0] SHORT_DLY_CNT   = 16'(SHORT_DLY_CYC);
	localparam logic [3:0]  PSEL_RST        = 4'h5;
	localparam logic [7:0]  WAIT_SP_OFFSET  = 8'h08;
	localparam logic [7:0]  PORT_RST_VAL    = 8'h00;
	localparam logic [3:0]  PORTA_RST_VAL   = 4'h0;

	// Core power states
	typedef enum logic [2:0] {
		SPC_RUN,
		SPC_WAIT,
		SPC_STOP,
		SPC_RECOVER,
		SPC_WAKE
	} spc_state_t;

	// Action requested of the core on wake
	typedef enum logic [1:0] {
		SPC_ACT_NONE,
		SPC_ACT_RESUME,
		SPC_ACT_NONMASKABLE_IRQ_PIN,
		SPC_ACT_IRQ
	} spc_act_t;
endpackage : spc_pkg

// File: rtl/spc_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Destination runs on clk_in
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module spc_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] rst_val_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// A zero-width stage has nothing to carry
	if (WIDTH < 1)
	begin : g_width_chk
		$error("spc_sync needs WIDTH of at least one");
	end

	// Pins idle high, so both stages reset to all ones
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			meta_r <= '1;
			sync_r <= '1;
		end
		else
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

	// Tie-off input is unused by the flops on purpose
	logic unused_ok;
	assign unused_ok = &rst_val_in | 1'b1;
endmodule : spc_sync

// File: rtl/spc_stop_ctrl.sv
// Purpose: Stop and wait mode control, wake-up and pin state control
// Assumes: Core supplies instruction strobes and condition code flags
// Notes:   Clock gate output is a level; a real chip needs a glitch-free gate
`timescale 1ns/10ps
module spc_stop_ctrl (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	// Core instruction and flags
	input  wire logic        stop_instr_in,
	input  wire logic        wait_instruction_in,
	input  wire logic        stop_disable_in,
	input  wire logic        nonmaskable_irq_pin_mask_in,
	input  wire logic        irq_mask_in,
	input  wire logic        restart_delay_select_in,
	input  wire logic [15:0] stack_ptr_in,
	input  wire logic        priority_wr_in,
	input  wire logic [3:0]  priority_wdata_in,
	// External pins
	input  wire logic        nonmaskable_irq_pin_n_in,
	input  wire logic        irq_pin_n_in,
	input  wire logic        mode_select_a_pin_in,
	// Core running values for the ports
	input  wire logic        bus_clk_in,
	input  wire logic        addr_strobe_in,
	input  wire logic        strobe_rw_in,
	input  wire logic [3:0]  porta_mid_in,
	input  wire logic [7:0]  portb_in,
	input  wire logic [7:0]  portc_in,
	input  wire logic [15:0] bus_addr_in,
	input  wire logic [7:0]  ddr_portc_in,
	input  wire logic [5:0]  ddr_portd_in,
	input  wire logic        ddr_porta7_in,
	// Control to the core
	output logic             clk_gate_en_out,
	output logic             osc_en_out,
	output logic             core_hold_out,
	output logic             stop_active_out,
	output logic             wait_active_out,
	output logic             stop_nop_out,
	output logic             wake_valid_out,
	output spc_pkg::spc_act_t wake_act_out,
	output logic             irq_unmasked_out,
	output logic [3:0]       priority_select_field_out,
	output logic             expanded_out,
	// Pin drive
	output logic             bus_clk_out,
	output logic             addr_strobe_output_out,
	output logic             strobe_or_read_write_output_out,
	output logic [3:0]       porta_mid_out,
	output logic [7:0]       portb_out,
	output logic [7:0]       portc_out,
	output logic [7:0]       portc_oe_n_out,
	output logic [5:0]       portd_oe_n_out,
	output logic             porta7_oe_n_out
);
	spc_pkg::spc_state_t state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [7:0]  wait_sp_r;
	logic        nonmaskable_irq_pin_sync, irq_sync;
	logic [1:0]  pin_sync;
	logic        mode_exp_r;
	logic        rst_phase_r;
	logic        nonmaskable_irq_pin_mask_at_wake_r;
	logic        wake_src_x_r;
	logic [3:0]  psel_r;
	logic [7:0]  held_portb_r;
	logic [3:0]  held_porta_r;
	logic        held_strb_r;

	// Pins arrive asynchronously
	spc_sync #(.WIDTH(2)) u_sync (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.async_in   ({nonmaskable_irq_pin_n_in, irq_pin_n_in}),
		.rst_val_in (2'h3),
		.sync_out   (pin_sync)
	);

	// Wake sources
	logic nonmaskable_irq_pin_wake;
	logic irq_wake;
	logic stop_go;
	logic [15:0] dly_load;
	assign nonmaskable_irq_pin_sync = pin_sync[1];
	assign irq_sync  = pin_sync[0];
	assign nonmaskable_irq_pin_wake = !nonmaskable_irq_pin_sync;
	assign irq_wake  = !irq_sync && !irq_mask_in;
	assign stop_go   = stop_instr_in && !stop_disable_in;
	assign stop_nop_out = stop_instr_in && stop_disable_in &&
		(state_r == spc_pkg::SPC_RUN);
	assign dly_load  = restart_delay_select_in ?
		spc_pkg::LONG_DLY_CNT : spc_pkg::SHORT_DLY_CNT;
	assign irq_unmasked_out = !irq_mask_in;
	// Next-state logic
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			spc_pkg::SPC_RUN:
			begin
				if (stop_go)
					state_nxt = spc_pkg::SPC_STOP;
				else if (wait_instruction_in)
					state_nxt = spc_pkg::SPC_WAIT;
			end
			spc_pkg::SPC_WAIT:
			begin
				if (nonmaskable_irq_pin_wake || irq_wake)
					state_nxt = spc_pkg::SPC_WAKE;
			end
			spc_pkg::SPC_STOP:
			begin
				if (nonmaskable_irq_pin_wake || irq_wake)
				begin
					state_nxt = spc_pkg::SPC_RECOVER;
					cnt_nxt   = dly_load - 16'h0001;
				end
			end
			spc_pkg::SPC_RECOVER:
			begin
				if (cnt_r == 16'h0000)
					state_nxt = spc_pkg::SPC_WAKE;
				else
					cnt_nxt = cnt_r - 16'h0001;
			end
			spc_pkg::SPC_WAKE:
				state_nxt = spc_pkg::SPC_RUN;
			default:
				state_nxt = spc_pkg::SPC_RUN;
		endcase
	end

	// State, counter; reset ends any mode and restarts at run
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_r <= spc_pkg::SPC_RUN;
			cnt_r   <= 16'h0000;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// Capture wake source and mask at the moment of wake
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			wake_src_x_r        <= 1'b0;
			nonmaskable_irq_pin_mask_at_wake_r <= 1'b1;
		end
		else if ((state_r == spc_pkg::SPC_STOP ||
			state_r == spc_pkg::SPC_WAIT) && (nonmaskable_irq_pin_wake || irq_wake))
		begin
			wake_src_x_r        <= nonmaskable_irq_pin_wake;
			nonmaskable_irq_pin_mask_at_wake_r <= nonmaskable_irq_pin_mask_in;
		end
	end

	// Wake action decode; the nonmaskable source wins when both pins are low
	logic wake_now;
	assign wake_now       = (state_r == spc_pkg::SPC_WAKE);
	assign wake_valid_out = wake_now;
	assign wake_act_out   = !wake_now ? spc_pkg::SPC_ACT_NONE :
		(!wake_src_x_r ? spc_pkg::SPC_ACT_IRQ :
		(nonmaskable_irq_pin_mask_at_wake_r ? spc_pkg::SPC_ACT_RESUME :
		spc_pkg::SPC_ACT_NONMASKABLE_IRQ_PIN));
	// Clock and oscillator gating
	logic in_stop;
	assign in_stop         = (state_r == spc_pkg::SPC_STOP);
	assign clk_gate_en_out = !in_stop &&
		(state_r != spc_pkg::SPC_RECOVER);
	assign osc_en_out      = !in_stop;
	assign core_hold_out   = (state_r != spc_pkg::SPC_RUN);
	assign stop_active_out = in_stop;
	assign wait_active_out = (state_r == spc_pkg::SPC_WAIT);
	// Mode strap caught on the first edge after reset release
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rst_phase_r <= 1'b1;
			mode_exp_r  <= 1'b0;
		end
		else
		begin
			rst_phase_r <= 1'b0;
			if (rst_phase_r)
				mode_exp_r <= mode_select_a_pin_in;
		end
	end
	assign expanded_out = mode_exp_r;
	// Priority field; software write only while masked
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			psel_r <= spc_pkg::PSEL_RST;
		else if (priority_wr_in && irq_mask_in)
			psel_r <= priority_wdata_in;
	end
	assign priority_select_field_out = psel_r;
	// Stack pointer capture at wait entry
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			wait_sp_r <= spc_pkg::PORT_RST_VAL;
		else if (state_r == spc_pkg::SPC_RUN && wait_instruction_in &&
			!stop_go)
			wait_sp_r <= stack_ptr_in[7:0] - spc_pkg::WAIT_SP_OFFSET;
	end

	// Held single-chip outputs; updated only while running
	logic low_power;
	assign low_power = (state_r != spc_pkg::SPC_RUN);
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			held_portb_r <= spc_pkg::PORT_RST_VAL;
			held_porta_r <= spc_pkg::PORTA_RST_VAL;
			held_strb_r  <= 1'b0;
		end
		else if (!low_power)
		begin
			held_portb_r <= portb_in;
			held_porta_r <= porta_mid_in;
			held_strb_r  <= strobe_rw_in;
		end
	end

	// Pin selection; reset phase treated like reset for pin states
	logic in_rst;
	assign in_rst = rst_phase_r;
	assign bus_clk_out = in_stop ? 1'b0 : bus_clk_in;
	assign addr_strobe_output_out = (mode_exp_r && !in_stop) ?
		addr_strobe_in : 1'b0;
	assign strobe_or_read_write_output_out = in_rst ? 1'b0 :
		(mode_exp_r ? 1'b1 : held_strb_r);
	assign porta_mid_out = in_rst ? spc_pkg::PORTA_RST_VAL :
		held_porta_r;
	assign portb_out = mode_exp_r ? bus_addr_in[15:8] :
		(in_rst ? spc_pkg::PORT_RST_VAL : held_portb_r);
	assign portc_out = !mode_exp_r ? portc_in :
		(wait_active_out ? wait_sp_r :
		(in_stop ? bus_addr_in[7:0] : portc_in));
	assign portc_oe_n_out = mode_exp_r ? 8'h00 :
		(in_rst ? 8'hFF : ~ddr_portc_in);
	assign portd_oe_n_out  = in_rst ? 6'h3F : ~ddr_portd_in;
	assign porta7_oe_n_out = in_rst ? 1'b1 : ~ddr_porta7_in;
	// Checks
	property p_stop_clk;
		@(posedge clk_in) disable iff (!reset_n_in)
		in_stop |-> !clk_gate_en_out && !osc_en_out && !bus_clk_out;
	endproperty
	a_stop_clk: assert property (p_stop_clk) else $error("clocks run");
	property p_nop_stop;
		@(posedge clk_in) disable iff (!reset_n_in)
		(state_r == spc_pkg::SPC_RUN && stop_instr_in && stop_disable_in)
		|=> state_r != spc_pkg::SPC_STOP;
	endproperty
	a_nop_stop: assert property (p_nop_stop) else $error("stop not nop");
	property p_stop_enter;
		@(posedge clk_in) disable iff (!reset_n_in)
		(state_r == spc_pkg::SPC_RUN && stop_go) |=> in_stop;
	endproperty
	a_stop_enter: assert property (p_stop_enter) else $error("no stop");
	property p_stay_stop;
		@(posedge clk_in) disable iff (!reset_n_in)
		(in_stop && !nonmaskable_irq_pin_wake && !irq_wake) |=> in_stop;
	endproperty
	a_stay_stop: assert property (p_stay_stop) else $error("bad exit");
	property p_short_dly;
		@(posedge clk_in) disable iff (!reset_n_in)
		(in_stop && nonmaskable_irq_pin_wake && !restart_delay_select_in)
		|=> (state_r == spc_pkg::SPC_RECOVER) [*4] ##1 wake_now;
	endproperty
	a_short_dly: assert property (p_short_dly) else $error("short dly");
	property p_long_dly;
		@(posedge clk_in) disable iff (!reset_n_in)
		(in_stop && (nonmaskable_irq_pin_wake || irq_wake) && restart_delay_select_in)
		|=> !wake_now [*8];
	endproperty
	a_long_dly: assert property (p_long_dly) else $error("long dly");
	property p_nonmaskable_irq_pin_svc;
		@(posedge clk_in) disable iff (!reset_n_in)
		(in_stop && nonmaskable_irq_pin_wake && !nonmaskable_irq_pin_mask_in && !restart_delay_select_in)
		|=> ##4 wake_act_out == spc_pkg::SPC_ACT_NONMASKABLE_IRQ_PIN;
	endproperty
	a_nonmaskable_irq_pin_svc: assert property (p_nonmaskable_irq_pin_svc) else $error("nonmaskable_irq_pin svc");
	property p_nonmaskable_irq_pin_res;
		@(posedge clk_in) disable iff (!reset_n_in)
		(in_stop && nonmaskable_irq_pin_wake && nonmaskable_irq_pin_mask_in && !restart_delay_select_in)
		|=> ##4 wake_act_out == spc_pkg::SPC_ACT_RESUME;
	endproperty
	a_nonmaskable_irq_pin_res: assert property (p_nonmaskable_irq_pin_res) else $error("nonmaskable_irq_pin res");
	property p_as_stop;
		@(posedge clk_in) disable iff (!reset_n_in)
		in_stop |-> !addr_strobe_output_out;
	endproperty
	a_as_stop: assert property (p_as_stop) else $error("strobe in stop");
	property p_wait_sp;
		@(posedge clk_in) disable iff (!reset_n_in)
		(state_r == spc_pkg::SPC_RUN && wait_instruction_in && !stop_go)
		|=> wait_sp_r == $past(stack_ptr_in[7:0]) - 8'h08;
	endproperty
	a_wait_sp: assert property (p_wait_sp) else $error("sp-8");
	c_stop_wake: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		in_stop ##[1:20] wake_now);
	c_wait_wake: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		wait_active_out ##1 wake_now);
	c_nop: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		stop_nop_out);
endmodule : spc_stop_ctrl

// File: tb/spc_irq_src.sv
// Purpose: Far-side model of the external interrupt sources
// Assumes: Both pins idle high, as terminated to the supply rail
// Notes:   lag_in sets how many cycles a source takes to pull its pin
`timescale 1ns/10ps
module spc_irq_src (
	// Clock
	input  wire logic       clk_in,
	// Requests from the bench
	input  wire logic       nmi_req_in,
	input  wire logic       irq_req_in,
	input  wire logic [3:0] lag_in,
	// Pins, active low
	output logic            nmi_pin_n_out,
	output logic            irq_pin_n_out
);
	logic [3:0] nmi_cnt_r;
	logic [3:0] irq_cnt_r;

	// Pins start released so no wake is seen before a request
	initial
	begin
		nmi_pin_n_out = 1'b1;
		irq_pin_n_out = 1'b1;
		nmi_cnt_r     = 4'h0;
		irq_cnt_r     = 4'h0;
	end

	// Slow sources pull late; a release lets the line float high at once
	always @(posedge clk_in)
	begin
		if (!nmi_req_in)
		begin
			nmi_cnt_r     <= 4'h0;
			nmi_pin_n_out <= 1'b1;
		end
		else if (nmi_cnt_r >= lag_in)
			nmi_pin_n_out <= 1'b0;
		else
			nmi_cnt_r <= nmi_cnt_r + 4'h1;
		if (!irq_req_in)
		begin
			irq_cnt_r     <= 4'h0;
			irq_pin_n_out <= 1'b1;
		end
		else if (irq_cnt_r >= lag_in)
			irq_pin_n_out <= 1'b0;
		else
			irq_cnt_r <= irq_cnt_r + 4'h1;
	end
endmodule : spc_irq_src

// File: tb/testbench.sv
// Purpose: Self-checking bench for the stop-mode power control block
// Assumes: 50 MHz clock, wake pins driven by the interrupt source model
// Notes:   Recovery length is counted as gated cycles before the wake pulse
`timescale 1ns/10ps
module testbench;
	logic clk_in, reset_n_in, stop_instr_in, wait_instruction_in;
	logic stop_disable_in, nonmaskable_irq_pin_mask_in, irq_mask_in, priority_wr_in;
	logic restart_delay_select_in, mode_select_a_pin_in, ddr_porta7_in;
	logic nonmaskable_irq_pin_n_in, irq_pin_n_in, bus_clk_in;
	logic addr_strobe_in, strobe_rw_in, nmi_req, irq_req;
	logic [15:0] stack_ptr_in, bus_addr_in;
	logic [3:0]  priority_wdata_in, porta_mid_in, lag;
	logic [7:0]  portb_in, portc_in, ddr_portc_in;
	logic [5:0]  ddr_portd_in;
	logic clk_gate_en_out, osc_en_out, core_hold_out, stop_active_out;
	logic wait_active_out, stop_nop_out, wake_valid_out, irq_unmasked_out;
	logic expanded_out, bus_clk_out, addr_strobe_output_out, porta7_oe_n_out;
	logic strobe_or_read_write_output_out;
	spc_pkg::spc_act_t wake_act_out;
	logic [3:0]  priority_select_field_out, porta_mid_out;
	logic [7:0]  portb_out, portc_out, portc_oe_n_out;
	logic [5:0]  portd_oe_n_out;
	int          err_total, n_tests, cyc;

	// Block under test and its interrupt sources
	spc_stop_ctrl uut (.*);
	spc_irq_src src (.clk_in(clk_in), .nmi_req_in(nmi_req),
		.irq_req_in(irq_req), .lag_in(lag),
		.nmi_pin_n_out(nonmaskable_irq_pin_n_in),
		.irq_pin_n_out(irq_pin_n_in));

	// Free-running clock
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// Hang guard, well above the longest recovery
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			err_total++;
			stop_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task stop_test;
		$display("mismatches=%0d checks=%0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// Reset for five cycles with the mode strap held
	task automatic do_reset(input logic mode_select_a_pin);
		@(posedge clk_in);
		reset_n_in           <= 1'b0;
		mode_select_a_pin_in <= mode_select_a_pin;
		repeat (4) @(posedge clk_in);
		#1;
		chk(stop_active_out, 1'b0);
		chk(porta7_oe_n_out, 1'b1);
		chk(portd_oe_n_out, 6'h3F);
		chk(priority_select_field_out, 4'h5);
		if (!mode_select_a_pin)
		begin
			chk(strobe_or_read_write_output_out, 1'b0);
			chk(porta_mid_out, 4'h0);
			chk(portb_out, 8'h00);
			chk(portc_oe_n_out, 8'hFF);
		end
		@(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask : do_reset

	// Stop pulse; refused when the disable flag is set
	task automatic do_stop(input logic exp_nop);
		@(posedge clk_in);
		stop_instr_in <= 1'b1;
		#1;
		chk(stop_nop_out, exp_nop);
		@(posedge clk_in);
		stop_instr_in <= 1'b0;
		#1;
		chk(stop_active_out, !exp_nop);
	endtask : do_stop

	// Wait for the wake pulse, count recovery cycles, then drop requests
	task automatic wake(input int dly, input spc_pkg::spc_act_t act);
		int cnt;
		cnt = 0;
		for (int i = 0; i < 6000 && wake_valid_out !== 1'b1; i++)
		begin
			@(posedge clk_in);
			#1;
			if (clk_gate_en_out === 1'b0 && stop_active_out === 1'b0 &&
				wake_valid_out !== 1'b1)
				cnt++;
		end
		chk(wake_valid_out, 1'b1);
		chk(16'(cnt), 16'(dly));
		chk(16'(wake_act_out), 16'(act));
		@(posedge clk_in);
		nmi_req <= 1'b0;
		irq_req <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : wake

	task automatic t_reset_nop;
		@(posedge clk_in);
		priority_wr_in    <= 1'b1;
		priority_wdata_in <= 4'hA;
		@(posedge clk_in);
		priority_wr_in <= 1'b0;
		#1;
		chk(priority_select_field_out, 4'hA);
		do_reset(1'b0);
		chk(irq_unmasked_out, 1'b0);
		@(posedge clk_in);
		stop_disable_in <= 1'b1;
		do_stop(1'b1);
		@(posedge clk_in);
		stop_disable_in <= 1'b0;
		#1;
		chk(stop_active_out, 1'b0);
		$display("reset and refused stop done");
	endtask : t_reset_nop

	task automatic t_irq_stop;
		@(posedge clk_in);
		portb_in     <= 8'h3C;
		porta_mid_in <= 4'h9;
		do_stop(1'b0);
		@(posedge clk_in);
		portb_in     <= 8'hC3;
		porta_mid_in <= 4'h6;
		irq_req      <= 1'b1;
		#1;
		chk(clk_gate_en_out, 1'b0);
		chk(osc_en_out, 1'b0);
		chk(bus_clk_out, 1'b0);
		repeat (20) @(posedge clk_in);
		#1;
		chk(portb_out, 8'h3C);
		chk(porta_mid_out, 4'h9);
		chk(portd_oe_n_out, 6'h15);
		chk(porta7_oe_n_out, 1'b0);
		chk(portc_oe_n_out, 8'h0F);
		chk(strobe_or_read_write_output_out, 1'b1);
		chk(core_hold_out, 1'b1);
		chk(stop_active_out, 1'b1);
		@(posedge clk_in);
		irq_mask_in <= 1'b0;
		wake(4, spc_pkg::SPC_ACT_IRQ);
		@(posedge clk_in);
		irq_mask_in <= 1'b1;
		$display("maskable wake done");
	endtask : t_irq_stop

	task automatic t_nmi(input logic dsel, input logic xm, input int dly,
		input spc_pkg::spc_act_t act, input logic [3:0] lg);
		@(posedge clk_in);
		restart_delay_select_in <= dsel;
		nonmaskable_irq_pin_mask_in            <= xm;
		lag                     <= lg;
		do_stop(1'b0);
		@(posedge clk_in);
		nmi_req <= 1'b1;
		wake(dly, act);
		$display("nonmaskable wake done");
	endtask : t_nmi

	task automatic t_expanded;
		do_stop(1'b0);
		do_reset(1'b1);
		chk(wake_valid_out, 1'b0);
		chk(expanded_out, 1'b1);
		@(posedge clk_in);
		bus_addr_in         <= 16'hA55A;
		stack_ptr_in        <= 16'h1234;
		wait_instruction_in <= 1'b1;
		@(posedge clk_in);
		wait_instruction_in <= 1'b0;
		stack_ptr_in        <= 16'h4321;
		@(posedge clk_in);
		#1;
		chk(wait_active_out, 1'b1);
		chk(portc_out, 8'h2C);
		chk(portb_out, 8'hA5);
		chk(bus_clk_out, 1'b1);
		chk(addr_strobe_output_out, 1'b1);
		@(posedge clk_in);
		irq_mask_in <= 1'b0;
		irq_req     <= 1'b1;
		wake(0, spc_pkg::SPC_ACT_IRQ);
		@(posedge clk_in);
		irq_mask_in <= 1'b1;
		do_stop(1'b0);
		chk(portc_out, 8'h5A);
		chk(strobe_or_read_write_output_out, 1'b1);
		chk(portb_out, 8'hA5);
		chk(addr_strobe_output_out, 1'b0);
		chk(bus_clk_out, 1'b0);
		@(posedge clk_in);
		nmi_req      <= 1'b1;
		nonmaskable_irq_pin_mask_in <= 1'b1;
		wake(4, spc_pkg::SPC_ACT_RESUME);
		$display("expanded mode done");
	endtask : t_expanded

	// Main sequence; strobe, bus clock and port C controls stay constant
	initial
	begin
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		{reset_n_in, stop_instr_in, wait_instruction_in, nmi_req} = 4'h0;
		{stop_disable_in, nonmaskable_irq_pin_mask_in, irq_req, priority_wr_in} = 4'h0;
		{restart_delay_select_in, mode_select_a_pin_in} = 2'h0;
		{irq_mask_in, bus_clk_in, addr_strobe_in, strobe_rw_in} = 4'hF;
		ddr_porta7_in = 1'b1;
		stack_ptr_in = 16'h0000;
		bus_addr_in = 16'h0000;
		{priority_wdata_in, porta_mid_in, lag} = 12'h0F0;
		{portb_in, portc_in, ddr_portc_in} = 24'hFF00F0;
		ddr_portd_in = 6'h2A;
		repeat (5) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		t_reset_nop();
		t_irq_stop();
		t_nmi(1'b1, 1'b1, 4064, spc_pkg::SPC_ACT_RESUME, 4'h0);
		t_nmi(1'b0, 1'b0, 4, spc_pkg::SPC_ACT_NONMASKABLE_IRQ_PIN, 4'h7);
		t_expanded();
		stop_test();
	end
endmodule : testbench
